// ===== fws_bus_cycle.sv
// single read or write cycle engine for the asynchronous flash bus
`timescale 1ns/1ps
`include "fws_cfg.svh"
module fws_bus_cycle
    import fws_pkg::*;
#(
    parameter int ACCESS_CYC = `FWS_ACCESS_CYC
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // request and answer
    input  wire fws_req_type req,
    output logic             done,
    output logic      [7:0]  rdata,
    // flash pins
    output fws_pins_type     pins,
    input  wire logic [7:0]  dq_i
);
    typedef enum logic [1:0] {
        BC_IDLE = 2'b00,
        BC_ACT  = 2'b01,
        BC_END  = 2'b10
    } fws_bc_type;

    fws_bc_type   st_q, st_d;
    logic [3:0]   cnt_q, cnt_d;
    logic [7:0]   rd_q, rd_d;
    fws_pins_type p_q, p_d;

    // strobes fall for the access time, data sampled just before release
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        rd_d  = rd_q;
        p_d   = p_q;
        unique case (st_q)
            BC_IDLE: begin
                if (req.go) begin
                    p_d.ce_n  = 1'b0;
                    p_d.oe_n  = req.wr;
                    p_d.we_n  = !req.wr;
                    p_d.addr  = req.addr;
                    p_d.dq_o  = req.wdata;
                    p_d.dq_oe = req.wr;
                    cnt_d     = 4'(ACCESS_CYC);
                    st_d      = BC_ACT;
                end
            end
            BC_ACT: begin
                if (cnt_q <= 4'h1) begin
                    rd_d     = dq_i;
                    p_d.ce_n = 1'b1;
                    p_d.oe_n = 1'b1;
                    p_d.we_n = 1'b1; // rising write edge latches data
                    st_d     = BC_END;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            BC_END: begin
                p_d.dq_oe = 1'b0; // hold data one cycle past we rise
                st_d      = BC_IDLE;
            end
            default: st_d = BC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q  <= BC_IDLE;
            cnt_q <= 4'h0;
            rd_q  <= 8'h00;
            p_q   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 21'h0,
                       dq_o: 8'h00, dq_oe: 1'b0};
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            rd_q  <= rd_d;
            p_q   <= p_d;
        end
    end

    assign done  = (st_q == BC_END);
    assign rdata = rd_q;
    assign pins  = p_q;
endmodule : fws_bus_cycle

// ===== fws_cfg.svh
// constants for the flash write status polling controller
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH
// register byte offsets
`define FWS_REG_CTRL      8'h00
`define FWS_REG_ADDR      8'h04
`define FWS_REG_DATA      8'h08
`define FWS_REG_STATUS    8'h0C
`define FWS_REG_RESULT    8'h10
// control field positions
`define FWS_CTRL_START    0
`define FWS_CTRL_MODE     1
`define FWS_CTRL_RSTCMD   2
// status bit positions on the data bus
`define FWS_POLL_BIT      7
`define FWS_TOGGLE1_BIT   6
`define FWS_LIMIT_BIT     5
`define FWS_ESTART_BIT    3
`define FWS_TOGGLE2_BIT   2
// reset command value and bus cycle timing
`define FWS_RESET_CMD     8'hF0
`define FWS_ACCESS_NS     70
`define FWS_CLK_NS        40
`define FWS_ACCESS_CYC    ((`FWS_ACCESS_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RESET_VAL     32'h0000_0000
`endif

// ===== fws_flash_model.sv
// behavioural flash device answering status reads on the parallel bus
`timescale 1ns/1ps
module fws_flash_model
    import fws_pkg::*;
(
    // launch of one embedded operation
    input  wire logic        go,
    input  wire logic        erase,
    input  wire logic        stuck,
    input  wire logic [7:0]  data,
    input  wire logic [7:0]  final_v,
    input  wire logic [7:0]  runs,
    input  wire logic [7:0]  lim_at,
    // flash pins
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [20:0] addr,
    input  wire logic [7:0]  dq_o,
    output logic      [7:0]  dq,
    output logic             busy_n,
    // observation
    output logic      [7:0]  rst_cnt,
    output logic      [20:0] last_addr
);
    logic       run = 1'b0;
    logic       tog1 = 1'b0;
    logic       tog2 = 1'b0;
    logic [7:0] nrd = 8'h00;
    logic [7:0] arr = 8'hFF;
    logic [7:0] last = 8'hFF;
    logic [7:0] rd_v;
    wire        rd_act = !ce_n && !oe_n;
    wire        wr_act = !ce_n && !we_n;
    // erase flagged stuck stands for a sector held in erase suspend
    wire        held = erase & stuck;
    initial begin
        rst_cnt = 8'h00;
        last_addr = 21'h000000;
    end
    // status byte while running, array byte otherwise
    always_comb begin
        rd_v = arr;
        if (run && held) begin
            rd_v = {1'b1, tog1, 3'b000, tog2, 2'b00};
        end else if (run) begin
            rd_v = {erase ? 1'b0 : ~data[7], tog1, nrd >= lim_at,
                    1'b0, erase, erase & tog2, 2'b00};
        end
    end
    // released bus shows the inverse, not a stale byte
    assign dq = rd_act ? rd_v : ~last;
    assign busy_n = !run || held;
    // status valid at once after launch, one sector only
    always @(posedge go) begin
        run = 1'b1;
        nrd = 8'h00;
        tog1 = 1'b0;
        tog2 = 1'b0;
    end
    // each completed read while running advances the toggles, except toggle 1 in a held sector
    always @(negedge rd_act) begin
        last = rd_v;
        last_addr = addr;
        if (run) begin
            nrd = nrd + 8'h01;
            tog1 = held ? tog1 : ~tog1;
            tog2 = ~tog2;
            if (!stuck && nrd >= runs) begin
                run = 1'b0;
                arr = final_v;
            end
        end
    end
    // reset command ends only a failed operation
    always @(negedge wr_act) begin
        if (dq_o == 8'hF0) begin
            rst_cnt = rst_cnt + 8'h01;
            if (nrd >= lim_at) run = 1'b0;
        end
    end
endmodule : fws_flash_model

// ===== fws_pkg.sv
// types for the flash write status polling controller
package fws_pkg;
    typedef enum logic [3:0] {
        FWS_IDLE    = 4'b0000,
        FWS_RD1     = 4'b0001,
        FWS_RD2     = 4'b0010,
        FWS_CHECK   = 4'b0011,
        FWS_RD3     = 4'b0100,
        FWS_RD4     = 4'b0101,
        FWS_RECHECK = 4'b0110,
        FWS_RSTCMD  = 4'b0111,
        FWS_FINAL   = 4'b1000,
        FWS_DONE    = 4'b1001
    } fws_state_type;

    typedef enum logic [1:0] {
        FWS_RES_NONE = 2'b00,
        FWS_RES_OK   = 2'b01,
        FWS_RES_FAIL = 2'b10
    } fws_result_type;

    // one flash bus request from the sequencer to the cycle engine
    typedef struct packed {
        logic        go;
        logic        wr;
        logic [20:0] addr;
        logic [7:0]  wdata;
    } fws_req_type;

    // flash pin group driven by the cycle engine
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [20:0] addr;
        logic [7:0]  dq_o;
        logic        dq_oe;
    } fws_pins_type;
endpackage : fws_pkg

// ===== fws_poll_ctrl.sv
// host-side controller that polls flash program and erase status
// How it works
// - host polls inside the sector being changed, never a protected one
// - poll bit may flip early; host takes data from a later read
// - after limit bit seen, host rechecks toggling
// - after a flagged failure host writes the reset command
// - host reads status twice in a row and compares toggle bit 6 only
// - still toggling with limit bit high means failure, then reset
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "fws_cfg.svh"
module fws_poll_ctrl
    import fws_pkg::*;
#(
    parameter int ACCESS_CYC = `FWS_ACCESS_CYC
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // flash control pins
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic      [20:0] flash_addr,
    // flash data pins
    input  wire logic [7:0]  flash_dq_i,
    output logic      [7:0]  flash_dq_o,
    output logic             flash_dq_oe,
    // open-drain busy line as seen at the host
    input  wire logic        busy_indicator_n
);
    fws_state_type  st_q, st_d;
    fws_result_type res_q, res_d;
    logic [7:0]     first_q, first_d;
    logic [7:0]     last_q, last_d;
    logic           busy_pin_q, busy_pin_d;
    fws_req_type    req;
    fws_pins_type   pins;
    logic           cyc_done;
    logic [7:0]     cyc_data;
    logic           start_pulse, rst_pulse, mode_erase;
    logic [20:0]    poll_addr;
    logic [7:0]     exp_data;
    logic           busy;

    // toggle bit 6 moved between two consecutive reads
    function automatic logic toggled(input logic [7:0] a,
                                     input logic [7:0] b);
        toggled = a[`FWS_TOGGLE1_BIT] ^ b[`FWS_TOGGLE1_BIT];
    endfunction : toggled

    fws_wb_regs u_regs (
        .clk         (clk),
        .rst_n       (rst_n),
        .wb_cyc_i    (wb_cyc_i),
        .wb_stb_i    (wb_stb_i),
        .wb_we_i     (wb_we_i),
        .wb_adr_i    (wb_adr_i),
        .wb_sel_i    (wb_sel_i),
        .wb_dat_i    (wb_dat_i),
        .wb_dat_o    (wb_dat_o),
        .wb_ack_o    (wb_ack_o),
        .start_pulse (start_pulse),
        .rst_pulse   (rst_pulse),
        .mode_erase  (mode_erase),
        .poll_addr   (poll_addr),
        .exp_data    (exp_data),
        .busy        (busy),
        .result      (res_q),
        .last_status (last_q),
        .busy_pin    (busy_pin_q)
    );

    fws_bus_cycle #(.ACCESS_CYC(ACCESS_CYC)) u_cycle (
        .clk   (clk),
        .rst_n (rst_n),
        .req   (req),
        .done  (cyc_done),
        .rdata (cyc_data),
        .pins  (pins),
        .dq_i  (flash_dq_i)
    );

    assign busy = (st_q != FWS_IDLE) && (st_q != FWS_DONE);

    // one bus request per read state, issued while the engine is idle
    always_comb begin
        req.go    = 1'b0;
        req.wr    = 1'b0;
        req.addr  = poll_addr;
        req.wdata = 8'h00;
        unique case (st_q)
            FWS_RD1, FWS_RD2, FWS_RD3, FWS_RD4, FWS_FINAL: begin
                req.go = !cyc_done;
            end
            FWS_RSTCMD: begin
                req.go    = !cyc_done;
                req.wr    = 1'b1;
                req.wdata = `FWS_RESET_CMD;
            end
            default: ;
        endcase
    end

    // toggle-check sequencer; read and write states advance when a bus cycle ends
    always_comb begin
        st_d       = st_q;
        res_d      = res_q;
        first_d    = first_q;
        last_d     = last_q;
        busy_pin_d = busy_indicator_n;
        unique case (st_q)
            FWS_IDLE, FWS_DONE: begin
                if (start_pulse) begin
                    res_d = FWS_RES_NONE;
                    st_d  = FWS_RD1;
                end else if (rst_pulse) begin
                    res_d = FWS_RES_NONE;
                    st_d  = FWS_RSTCMD;
                end
            end
            FWS_RD1: begin
                if (cyc_done) begin
                    first_d = cyc_data;
                    last_d  = cyc_data;
                    st_d    = FWS_RD2;
                end
            end
            FWS_RD2: begin
                if (cyc_done) begin
                    last_d = cyc_data;
                    st_d   = FWS_CHECK;
                end
            end
            FWS_CHECK: begin
                if (!toggled(first_q, last_q)) begin
                    st_d = FWS_FINAL;
                end else if (last_q[`FWS_LIMIT_BIT]) begin
                    st_d = FWS_RD3;
                end else begin
                    first_d = last_q;
                    st_d    = FWS_RD2; // still running, keep reading
                end
            end
            FWS_RD3: begin
                if (cyc_done) begin
                    first_d = cyc_data;
                    st_d    = FWS_RD4;
                end
            end
            FWS_RD4: begin
                if (cyc_done) begin
                    last_d = cyc_data;
                    st_d   = FWS_RECHECK;
                end
            end
            FWS_RECHECK: begin
                // toggling that stopped just as the limit bit rose goes on to the final read; still toggling is failure
                if (toggled(first_q, last_q)) begin
                    res_d = FWS_RES_FAIL;
                    st_d  = FWS_RSTCMD;
                end else begin
                    st_d = FWS_FINAL;
                end
            end
            FWS_RSTCMD: begin
                if (cyc_done) begin
                    st_d = FWS_DONE;
                end
            end
            FWS_FINAL: begin
                // fresh read: early poll-bit flip may leave low bits stale
                if (cyc_done) begin
                    last_d = cyc_data;
                    if (mode_erase) begin
                        res_d = cyc_data[`FWS_POLL_BIT] ? FWS_RES_OK
                                                        : FWS_RES_FAIL;
                    end else begin
                        res_d = (cyc_data == exp_data) ? FWS_RES_OK
                                                       : FWS_RES_FAIL;
                    end
                    st_d = FWS_DONE;
                end
            end
            default: st_d = FWS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q       <= FWS_IDLE;
            res_q      <= FWS_RES_NONE;
            first_q    <= 8'h00;
            last_q     <= 8'h00;
            busy_pin_q <= 1'b1;
        end else begin
            st_q       <= st_d;
            res_q      <= res_d;
            first_q    <= first_d;
            last_q     <= last_d;
            busy_pin_q <= busy_pin_d; // mirrored for software
        end
    end

    // pins come straight from engine flip-flops
    assign flash_ce_n  = pins.ce_n;
    assign flash_oe_n  = pins.oe_n;
    assign flash_we_n  = pins.we_n;
    assign flash_addr  = pins.addr;
    assign flash_dq_o  = pins.dq_o;
    assign flash_dq_oe = pins.dq_oe;
endmodule : fws_poll_ctrl

// ===== fws_poll_ctrl_bench.sv
// self-checking bench for the flash status polling controller
`timescale 1ns/1ps
`include "fws_cfg.svh"
module fws_poll_ctrl_bench;
    import fws_pkg::*;
    logic        clk, rst_n, cyc, stb, we, ack, go, m_er, m_st;
    logic        ce_n, oe_n, we_n, dq_oe, busy_n;
    logic [3:0]  sel;
    logic [7:0]  adr, dq_o, dq_m, dq_i, m_d, m_f, m_r, m_l, rcnt;
    logic [20:0] faddr, laddr;
    logic [31:0] wdat, rdat;
    int          n_mismatch = 0;
    int          num_checks = 0;
    assign dq_i = dq_oe ? dq_o : dq_m;
    fws_poll_ctrl #(.ACCESS_CYC(2)) fws_poll_ctrl_i (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
        .flash_dq_i(dq_i), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
        .busy_indicator_n(busy_n));
    fws_flash_model fws_flash_model_i (
        .go(go), .erase(m_er), .stuck(m_st), .data(m_d), .final_v(m_f),
        .runs(m_r), .lim_at(m_l), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(faddr), .dq_o(dq_o), .dq(dq_m), .busy_n(busy_n),
        .rst_cnt(rcnt), .last_addr(laddr));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
    endtask : wb
    function automatic logic [31:0] exp_res(input int k);
        return (k == 0 || k == 1 || k == 4 || k == 6) ? 32'h1 : 32'h2;
    endfunction : exp_res
    initial begin
        logic [31:0] q;
        logic [20:0] a;
        logic [7:0]  d, f, r0;
        logic        er;
        int          k, n;
        {rst_n, cyc, stb, we, go, m_er, m_st} = '0;
        {adr, sel, wdat, m_d, m_f, m_r, m_l} = '0;
        void'($urandom(16181));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, `FWS_REG_RESULT, 32'h0, q);
        chk("result reset", 32'h0, q);
        wb(1'b0, 8'h14, 32'h0, q);
        chk("unmapped", 32'h0, q);
        // cases: program ok, erase ok, protected program,
        // stuck with limit, limit then done, protected erase,
        // read inside an erase-suspended sector
        for (int t = 0; t < 14; t++) begin
            k = t % 7;
            a = 21'($urandom());
            d = 8'($urandom());
            f = (k == 1) ? 8'hFF : (k == 2) ? ~d : (k == 6) ? 8'h80 :
                (k == 5) ? (8'($urandom()) & 8'h7F) : d;
            r0 = rcnt;
            er = (k == 1 || k == 5 || k == 6);
            m_d <= d;
            m_f <= f;
            m_er <= er;
            m_st <= (k == 3 || k == 6);
            m_r <= (k == 4) ? 8'h02 : 8'h02 + 8'($urandom_range(4));
            m_l <= (k == 3 || k == 4) ? 8'h01 : 8'hFF;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            wb(1'b1, `FWS_REG_ADDR, {11'h0, a}, q);
            wb(1'b1, `FWS_REG_DATA, {24'h0, d}, q);
            wb(1'b0, `FWS_REG_STATUS, 32'h0, q);
            chk("busy pin low", {31'h0, k == 6}, {31'h0, q[9]});
            wb(1'b1, `FWS_REG_CTRL, {30'h0, er, 1'b1}, q);
            wb(1'b0, `FWS_REG_CTRL, 32'h0, q);
            chk("mode", {31'h0, er}, {31'h0, q[1]});
            n = 0;
            do begin
                wb(1'b0, `FWS_REG_STATUS, 32'h0, q);
                n++;
            end while (q[8] !== 1'b0 && n < 400);
            chk("busy end", 32'h0, {31'h0, q[8]});
            if (q[8] !== 1'b0) finish_test();
            if (k != 3) chk("last byte", {24'h0, f}, {24'h0, q[7:0]});
            wb(1'b0, `FWS_REG_RESULT, 32'h0, q);
            chk("result", exp_res(k), q);
            chk("reset cmds", {31'h0, k == 3}, {24'h0, rcnt - r0});
            chk("poll addr", {11'h0, a}, {11'h0, laddr});
            wb(1'b0, `FWS_REG_STATUS, 32'h0, q);
            chk("busy pin high", 32'h1, {31'h0, q[9]});
            $display("test %0d kind %0d done", t, k);
        end
        finish_test();
    end
endmodule : fws_poll_ctrl_bench

// ===== fws_poll_ctrl_properties.sv
// bound checker for the flash status polling controller ports
`timescale 1ns/1ps
module fws_poll_ctrl_chk
    import fws_pkg::*;
#(
    parameter int ACCESS_CYC = 2
)(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // wishbone
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // flash pins
    input wire logic       flash_ce_n,
    input wire logic       flash_oe_n,
    input wire logic       flash_we_n,
    input wire logic [7:0] flash_dq_o,
    input wire logic       flash_dq_oe
);
    logic [7:0] low_q;
    logic [7:0] low_d;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // length of the current read strobe in cycles
    always_comb begin
        low_d = (!rst_n || flash_oe_n) ? 8'h00 : low_q + 8'h01;
    end
    always_ff @(posedge clk) begin
        low_q <= low_d;
    end
    sequence rd_end;
        $rose(flash_oe_n);
    endsequence
    sequence wb_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_on_take_a: assert property (wb_take |=> wb_ack_o)
        else $error("ack missing after request");
    ack_needs_req_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    read_width_a: assert property (rd_end |-> low_q == ACCESS_CYC)
        else $error("read strobe width wrong");
    read_gap_a: assert property (rd_end |=> flash_oe_n)
        else $error("reads not separated");
    read_pair_a: assert property ($fell(flash_oe_n) |->
        $fell(flash_ce_n) && flash_we_n)
        else $error("read strobes not paired");
    bus_free_a: assert property (!flash_oe_n |-> !flash_dq_oe)
        else $error("data driven during read");
    reset_cmd_a: assert property ($rose(flash_we_n) |->
        flash_dq_o == 8'hF0 && flash_dq_oe ##1 !flash_dq_oe)
        else $error("reset command write wrong");
endmodule : fws_poll_ctrl_chk

bind fws_poll_ctrl fws_poll_ctrl_chk #(.ACCESS_CYC(ACCESS_CYC)) fws_poll_ctrl_chk_i (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe));

// ===== fws_wb_regs.sv
// wishbone slave register file for the polling controller
`timescale 1ns/1ps
`include "fws_cfg.svh"
module fws_wb_regs
    import fws_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // controller side
    output logic             start_pulse,
    output logic             rst_pulse,
    output logic             mode_erase,
    output logic      [20:0] poll_addr,
    output logic      [7:0]  exp_data,
    input  wire logic        busy,
    input  wire logic [1:0]  result,
    input  wire logic [7:0]  last_status,
    input  wire logic        busy_pin
);
    logic        ack_q, ack_d;
    logic        mode_q, mode_d;
    logic [20:0] addr_q, addr_d;
    logic [7:0]  data_q, data_d;
    logic [31:0] rdat_q, rdat_d;
    logic        st_q, st_d, rc_q, rc_d;
    logic        wr_hit;

    // one-cycle ack, dropped the cycle after it was given
    always_comb begin
        wr_hit = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i;
        ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
        mode_d = mode_q;
        addr_d = addr_q;
        data_d = data_q;
        st_d   = 1'b0;
        rc_d   = 1'b0;
        rdat_d = 32'h0000_0000;
        if (wr_hit && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                `FWS_REG_CTRL: begin
                    st_d   = wb_dat_i[`FWS_CTRL_START] && !busy;
                    mode_d = wb_dat_i[`FWS_CTRL_MODE];
                    rc_d   = wb_dat_i[`FWS_CTRL_RSTCMD] && !busy;
                end
                `FWS_REG_ADDR: addr_d = wb_dat_i[20:0];
                `FWS_REG_DATA: data_d = wb_dat_i[7:0];
                default: ;
            endcase
        end
        // unmapped reads answer zero
        unique case (wb_adr_i)
            `FWS_REG_CTRL:   rdat_d = {30'h0, mode_q, 1'b0};
            `FWS_REG_ADDR:   rdat_d = {11'h0, addr_q};
            `FWS_REG_DATA:   rdat_d = {24'h0, data_q};
            `FWS_REG_STATUS: rdat_d = {22'h0, busy_pin, busy, last_status};
            `FWS_REG_RESULT: rdat_d = {30'h0, result};
            default:         rdat_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q  <= 1'b0;
            mode_q <= 1'b0;
            addr_q <= 21'h00_0000;
            data_q <= 8'h00;
            rdat_q <= `FWS_RESET_VAL;
            st_q   <= 1'b0;
            rc_q   <= 1'b0;
        end else begin
            ack_q  <= ack_d;
            mode_q <= mode_d;
            addr_q <= addr_d;
            data_q <= data_d;
            rdat_q <= rdat_d;
            st_q   <= st_d;
            rc_q   <= rc_d;
        end
    end

    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rdat_q;
    assign start_pulse = st_q;
    assign rst_pulse   = rc_q;
    assign mode_erase  = mode_q;
    assign poll_addr   = addr_q;
    assign exp_data    = data_q;
endmodule : fws_wb_regs
